// ===== usb_ctl_pkg.sv
// Package with register map, fields, reset values and sizes of the USB device control block
// What this block does
// (RULE1) Endpoint FIFO port read pops one byte, write pushes one byte; an endpoint 1 port read pops nothing while ep1_split is low.
// (RULE2) Split endpoint: port reads pop OUT FIFO, port writes push IN FIFO.
// (RULE3) Seven-bit function address; new value used only after current transfer ends.
// (RULE4) Address pending bit seven sets on write, clears when address takes effect.
// (RULE5) Bus reset: status set, address zero, FIFOs flushed, index zeroed, irq setup.
// (RULE6) Writing one to core reset bit resets every USB register to default.
// (RULE7) Suspend detect enabled: suspend signaling sets suspend flag; suspend interrupt needs its enable, which no reset sets.
// (RULE8) Suspend ends on resume, bus reset, device reset or core reset.
// (RULE9) Resume signaling while suspended raises resume interrupt when enabled.
// (RULE10) Software clears resume bit ten to fifteen milliseconds after setting it.
// (RULE11) Iso update: hold new iso IN packets until next SOF, else zero-length.
// (RULE12) Core inhibited after power-on; only power-on or core reset sets inhibit again.
// (RULE13) Software configures clock, reset, transceiver, interrupts, then clears inhibit.
// (RULE14) Last frame number kept: low byte and high bits in read-only registers.
// (RULE15) Interrupt request asserted while any interrupt flag is set.
// (RULE16) Reading an interrupt flag register returns it and clears all its flags.
// (RULE17) IN flags: ep0 bit 0, ep1 IN bit 1; OUT flags: ep1 OUT bit 1.
// (RULE18) Suspend flag clears when resume bit cleared or bus resume detected.
package usb_ctl_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [5:0] ADDR_FUNC_ADDR  = 6'h00;
  localparam logic [5:0] ADDR_POWER      = 6'h01;
  localparam logic [5:0] ADDR_IN_FLAGS   = 6'h02;
  localparam logic [5:0] ADDR_COMMON     = 6'h06;
  localparam logic [5:0] ADDR_OUT_FLAGS  = 6'h04;
  localparam logic [5:0] ADDR_FRAME_LO   = 6'h0C;
  localparam logic [5:0] ADDR_FRAME_HI   = 6'h0D;
  localparam logic [5:0] ADDR_INDEX      = 6'h0E;
  localparam logic [5:0] ADDR_FIFO_EP0   = 6'h20;
  localparam logic [5:0] ADDR_FIFO_EP1   = 6'h21;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_FUNC_ADDR   = 8'h00;
  localparam logic [7:0] RST_POWER       = 8'h10;
  localparam logic [7:0] RST_IN_IE       = 8'h03;
  localparam logic [7:0] RST_OUT_IE      = 8'h02;
  localparam logic [3:0] RST_COMMON_IE   = 4'h6;
  localparam logic [3:0] BUSRST_COMMON_IE = 4'hE;
  // ==========================================================================
  // Power register field positions
  localparam int P_SUSPEND_EN  = 0;
  localparam int P_SUSPEND_ST  = 1;
  localparam int P_RESUME      = 2;
  localparam int P_CORE_RST    = 3;
  localparam int P_INHIBIT     = 4;
  localparam int P_ISO_SYNC    = 7;
  // Common flag positions
  localparam int C_SUSPEND = 0;
  localparam int C_RESUME  = 1;
  localparam int C_RESET   = 2;
  localparam int C_SOF     = 3;
  // Flag positions in endpoint flag registers
  localparam int F_EP0     = 0;
  localparam int F_EP1     = 1;
  // ==========================================================================
  // Sizes
  localparam int FIFO_EP0_DEPTH = 64;
  localparam int FIFO_IN1_DEPTH = 64;
  localparam int FIFO_OUT1_DEPTH = 128;
  localparam int FRAME_W = 11;
endpackage

// ===== usb_fifo_ram.sv
// Byte FIFO with registered read data, used for each endpoint buffer
`timescale 1ns/1ps
`default_nettype none
module usb_fifo_ram #(
  parameter int DEPTH = 64
) (
  input  wire logic       clk_sys,
  input  wire logic       clr,
  input  wire logic       push,
  input  wire logic [7:0] push_data,
  input  wire logic       pop,
  output logic [7:0]      pop_data,
  output logic            empty,
  output logic            full
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  // ==========================================================================
  // Pointers; extra bit tells full from empty
  assign empty = (wr_q == rd_q);
  assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);

  // Write side; pushes into a full buffer are dropped
  always_ff @(posedge clk_sys)
  begin
    if (clr)
      wr_q <= '0;
    else if (push && !full)
    begin
      mem[wr_q[AW-1:0]] <= push_data;
      wr_q <= wr_q + 1'b1;
    end
  end

  // Read side; data registered, popping empty returns zero
  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      rd_q     <= '0;
      pop_data <= 8'h00;
    end
    else if (pop)
    begin
      if (!empty)
      begin
        pop_data <= mem[rd_q[AW-1:0]];
        rd_q     <= rd_q + 1'b1;
      end
      else
        pop_data <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== usb_device_ctl.sv
// Top of the USB device control block: registers, power management, FIFO ports
`timescale 1ns/1ps
`default_nettype none
module usb_device_ctl
  import usb_ctl_pkg::*;
#(
  parameter int EP0_DEPTH  = usb_ctl_pkg::FIFO_EP0_DEPTH,
  parameter int IN1_DEPTH  = usb_ctl_pkg::FIFO_IN1_DEPTH,
  parameter int OUT1_DEPTH = usb_ctl_pkg::FIFO_OUT1_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Processor register port
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  // Events from the serial engine, one-cycle pulses; sof_frame and the ep1_split and ep1_iso modes are levels
  input  wire logic       bus_reset_det,
  input  wire logic       bus_suspend_det,
  input  wire logic       bus_resume_det,
  input  wire logic       sof_det,
  input  wire logic [10:0] sof_frame,
  input  wire logic       transfer_end,
  input  wire logic       ep0_event,
  input  wire logic       in1_event,
  input  wire logic       out1_event,
  input  wire logic       ep1_split,
  input  wire logic       ep1_iso,
  // Serial engine FIFO side
  input  wire logic       sie_ep0_push,
  input  wire logic       sie_ep0_pop,
  input  wire logic       sie_out1_push,
  input  wire logic       sie_in1_pop,
  input  wire logic [7:0] sie_wdata,
  output logic [7:0]      sie_ep0_rdata,
  output logic [7:0]      sie_in1_rdata,
  output logic            ep0_empty,
  output logic            in1_empty,
  output logic            out1_full,
  // In-token answer control for iso endpoint
  input  wire logic       iso_in_loaded,
  output logic            iso_send_zlp,
  // Device state
  output logic [6:0]      match_addr,
  output logic            core_inhibit,
  output logic            suspend_state_flag,
  output logic            resume_drive,
  output logic            usb_irq
);
  import usb_ctl_pkg::*;

  // ==========================================================================
  // Registers
  logic [6:0] addr_active_q;
  logic [6:0] addr_new_q;
  logic       addr_pend_q;
  logic       iso_sync_q;
  logic       inhibit_q;
  logic       resume_q;
  logic       suspend_q;
  logic       suspend_en_q;
  logic       bus_rst_st_q;
  logic [7:0] in_flags_q;
  logic [7:0] out_flags_q;
  logic [3:0] common_q;
  logic [7:0] in_ie_q;
  logic [7:0] out_ie_q;
  logic [3:0] common_ie_q;
  logic [7:0] index_q;
  logic [10:0] frame_q;
  logic       iso_held_q;
  logic       core_rst_q;
  logic [7:0] rdata_d;

  logic wr_hit;
  logic rd_hit;
  logic hard_rst;
  logic soft_clr;

  assign wr_hit = reg_wr && !inhibit_q;
  assign rd_hit = reg_rd;

  // ==========================================================================
  // Core reset: one-cycle pulse that resets all registers except the read-data pipeline next cycle
  // Registered so the write that asks for it completes cleanly first
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      core_rst_q <= 1'b0;
    // (RULE6) Core reset trigger
    else
      core_rst_q <= reg_wr && (reg_addr == ADDR_POWER) && reg_wdata[P_CORE_RST];
  end

  // (RULE6) Whole core back to defaults
  assign hard_rst = rst || core_rst_q;
  // (RULE5) Bus reset clear
  assign soft_clr = hard_rst || bus_reset_det;

  // ==========================================================================
  // Function address with deferred update
  always_ff @(posedge clk_sys)
  begin
    if (soft_clr)
    begin
      addr_active_q <= RST_FUNC_ADDR[6:0];
      addr_new_q    <= RST_FUNC_ADDR[6:0];
      addr_pend_q   <= 1'b0;
    end
    // (RULE3) Store new address only
    else if (wr_hit && reg_addr == ADDR_FUNC_ADDR)
    begin
      addr_new_q  <= reg_wdata[6:0];
      // (RULE4) Pending on write
      addr_pend_q <= 1'b1;
    end
    // (RULE3) Take effect at transfer end
    else if (addr_pend_q && transfer_end)
    begin
      addr_active_q <= addr_new_q;
      // (RULE4) Pending clears on effect
      addr_pend_q   <= 1'b0;
    end
  end

  assign match_addr = addr_active_q;

  // ==========================================================================
  // Inhibit: set only by device reset or core reset
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
      inhibit_q <= RST_POWER[P_INHIBIT];
    // (RULE12) Software may only clear it
    else if (reg_wr && reg_addr == ADDR_POWER && !reg_wdata[P_INHIBIT])
      inhibit_q <= 1'b0;
  end

  assign core_inhibit = inhibit_q;

  // ==========================================================================
  // Power control bits
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
    begin
      iso_sync_q   <= RST_POWER[P_ISO_SYNC];
      resume_q     <= RST_POWER[P_RESUME];
      suspend_en_q <= RST_POWER[P_SUSPEND_EN];
    end
    else if (reg_wr && reg_addr == ADDR_POWER)
    begin
      iso_sync_q   <= reg_wdata[P_ISO_SYNC];
      resume_q     <= reg_wdata[P_RESUME];
      suspend_en_q <= reg_wdata[P_SUSPEND_EN];
    end
  end

  // (RULE10) Software times the resume pulse
  assign resume_drive = resume_q;

  // Bus reset status follows the detector until the next suspend, resume or SOF
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
      bus_rst_st_q <= 1'b0;
    // (RULE5) Reset status set
    else if (bus_reset_det)
      bus_rst_st_q <= 1'b1;
    else if (bus_suspend_det || bus_resume_det || sof_det)
      bus_rst_st_q <= 1'b0;
  end

  // ==========================================================================
  // Suspend state
  always_ff @(posedge clk_sys)
  begin
    // (RULE8) Resets end suspend
    if (soft_clr)
      suspend_q <= 1'b0;
    // (RULE7) Enter suspend
    else if (bus_suspend_det && suspend_en_q && !suspend_q)
      suspend_q <= 1'b1;
    // (RULE18) Resume clears flag
    else if (bus_resume_det ||
             (reg_wr && reg_addr == ADDR_POWER && resume_q && !reg_wdata[P_RESUME]))
      suspend_q <= 1'b0;
  end

  assign suspend_state_flag = suspend_q;

  // ==========================================================================
  // Interrupt enables; bus reset turns on all but suspend
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
    begin
      in_ie_q     <= RST_IN_IE;
      out_ie_q    <= RST_OUT_IE;
      common_ie_q <= RST_COMMON_IE;
    end
    // (RULE5) Enable all except suspend
    else if (bus_reset_det)
    begin
      in_ie_q     <= RST_IN_IE;
      out_ie_q    <= RST_OUT_IE;
      common_ie_q <= BUSRST_COMMON_IE;
    end
  end

  // ==========================================================================
  // Flag registers: set wins over read clear
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
    begin
      in_flags_q  <= 8'h00;
      out_flags_q <= 8'h00;
    end
    // (RULE5) Flags cleared on bus reset
    else if (bus_reset_det)
    begin
      in_flags_q  <= 8'h00;
      out_flags_q <= 8'h00;
    end
    else
    begin
      // (RULE16) Read clears; (RULE17) bit layout
      if (rd_hit && reg_addr == ADDR_IN_FLAGS)
        in_flags_q <= 8'h00;
      if (rd_hit && reg_addr == ADDR_OUT_FLAGS)
        out_flags_q <= 8'h00;
      if (ep0_event && in_ie_q[F_EP0])
        in_flags_q[F_EP0] <= 1'b1;
      if (in1_event && in_ie_q[F_EP1])
        in_flags_q[F_EP1] <= 1'b1;
      if (out1_event && out_ie_q[F_EP1])
        out_flags_q[F_EP1] <= 1'b1;
    end
  end

  // Common flags
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
      common_q <= 4'h0;
    else
    begin
      if (rd_hit && reg_addr == ADDR_COMMON)
        common_q <= 4'h0;
      // (RULE5) Reset interrupt if enabled
      if (bus_reset_det)
        common_q <= {1'b0, common_ie_q[C_RESET], 2'b00};
      else
      begin
        // (RULE7) Suspend interrupt
        if (bus_suspend_det && suspend_en_q && !suspend_q && common_ie_q[C_SUSPEND])
          common_q[C_SUSPEND] <= 1'b1;
        // (RULE9) Resume interrupt
        if (bus_resume_det && suspend_q && common_ie_q[C_RESUME])
          common_q[C_RESUME] <= 1'b1;
        if (sof_det && common_ie_q[C_SOF])
          common_q[C_SOF] <= 1'b1;
      end
    end
  end

  // (RULE15) Any flag raises request
  assign usb_irq = (|in_flags_q) || (|out_flags_q) || (|common_q);

  // ==========================================================================
  // Index register, cleared on bus reset
  always_ff @(posedge clk_sys)
  begin
    if (soft_clr)
      index_q <= 8'h00;
    else if (wr_hit && reg_addr == ADDR_INDEX)
      index_q <= reg_wdata;
  end

  // ==========================================================================
  // Frame number capture
  always_ff @(posedge clk_sys)
  begin
    if (hard_rst)
      frame_q <= '0;
    // (RULE14) Keep last frame
    else if (sof_det && !inhibit_q)
      frame_q <= sof_frame;
  end

  // ==========================================================================
  // Iso update hold: a loaded packet waits for the next SOF
  always_ff @(posedge clk_sys)
  begin
    if (soft_clr)
      iso_held_q <= 1'b0;
    // (RULE11) Hold new iso packet; a load at SOF waits for the next one
    else if (iso_sync_q && iso_in_loaded)
      iso_held_q <= 1'b1;
    else if (sof_det)
      iso_held_q <= 1'b0;
  end

  // (RULE11) Zero-length answer before SOF
  assign iso_send_zlp = iso_sync_q && ep1_iso && iso_held_q;

  // ==========================================================================
  // FIFO port decode
  logic cpu_ep0_rd;
  logic cpu_ep0_wr;
  logic cpu_ep1_rd;
  logic cpu_ep1_wr;
  logic [7:0] ep0_rdata;
  logic [7:0] out1_rdata;
  logic in1_full;
  logic out1_empty;
  logic ep0_full;

  // (RULE1) One byte per access
  assign cpu_ep0_rd = rd_hit && reg_addr == ADDR_FIFO_EP0;
  assign cpu_ep0_wr = wr_hit && reg_addr == ADDR_FIFO_EP0;
  // (RULE2) Split direction steering
  assign cpu_ep1_rd = rd_hit && reg_addr == ADDR_FIFO_EP1 && ep1_split;
  assign cpu_ep1_wr = wr_hit && reg_addr == ADDR_FIFO_EP1;

  // Endpoint 0 is one buffer shared by both directions
  usb_fifo_ram #(.DEPTH(EP0_DEPTH)) u_ep0 (
    .clk_sys   (clk_sys),
    .clr       (soft_clr),
    .push      (cpu_ep0_wr || sie_ep0_push),
    .push_data (cpu_ep0_wr ? reg_wdata : sie_wdata),
    .pop       (cpu_ep0_rd || sie_ep0_pop),
    .pop_data  (ep0_rdata),
    .empty     (ep0_empty),
    .full      (ep0_full)
  );

  usb_fifo_ram #(.DEPTH(IN1_DEPTH)) u_in1 (
    .clk_sys   (clk_sys),
    .clr       (soft_clr),
    .push      (cpu_ep1_wr),
    .push_data (reg_wdata),
    .pop       (sie_in1_pop),
    .pop_data  (sie_in1_rdata),
    .empty     (in1_empty),
    .full      (in1_full)
  );

  usb_fifo_ram #(.DEPTH(OUT1_DEPTH)) u_out1 (
    .clk_sys   (clk_sys),
    .clr       (soft_clr),
    .push      (sie_out1_push),
    .push_data (sie_wdata),
    .pop       (cpu_ep1_rd),
    .pop_data  (out1_rdata),
    .empty     (out1_empty),
    .full      (out1_full)
  );

  assign sie_ep0_rdata = ep0_rdata;

  // ==========================================================================
  // Read data mux; FIFO reads are answered one cycle later from RAM output
  logic fifo_rd_q;
  logic fifo_sel_q;
  logic [7:0] rdata_q;
  logic rvalid_q;

  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_addr == ADDR_FUNC_ADDR)
      rdata_d = {addr_pend_q, addr_new_q};
    else if (reg_addr == ADDR_POWER)
      rdata_d = {iso_sync_q, 2'b00, inhibit_q, bus_rst_st_q, resume_q, suspend_q, suspend_en_q};
    else if (reg_addr == ADDR_IN_FLAGS)
      rdata_d = in_flags_q;
    else if (reg_addr == ADDR_OUT_FLAGS)
      rdata_d = out_flags_q;
    else if (reg_addr == ADDR_COMMON)
      rdata_d = {4'h0, common_q};
    else if (reg_addr == ADDR_FRAME_LO)
      rdata_d = frame_q[7:0];
    else if (reg_addr == ADDR_FRAME_HI)
      rdata_d = {5'b00000, frame_q[10:8]};
    else if (reg_addr == ADDR_INDEX)
      rdata_d = index_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_q    <= 8'h00;
      rvalid_q   <= 1'b0;
      fifo_rd_q  <= 1'b0;
      fifo_sel_q <= 1'b0;
    end
    else
    begin
      rvalid_q   <= reg_rd && !(reg_addr == ADDR_FIFO_EP0 || reg_addr == ADDR_FIFO_EP1);
      fifo_rd_q  <= reg_rd && (reg_addr == ADDR_FIFO_EP0 || reg_addr == ADDR_FIFO_EP1);
      fifo_sel_q <= (reg_addr == ADDR_FIFO_EP1);
      if (reg_rd)
        rdata_q <= rdata_d;
    end
  end

  // Flag reads hand back the value before their clear lands
  assign reg_rvalid = rvalid_q || fifo_rd_q;
  assign reg_rdata  = fifo_rd_q ? (fifo_sel_q ? out1_rdata : ep0_rdata) : rdata_q;
endmodule
`default_nettype wire

// ===== usb_device_ctl_properties.sv
// Concurrent checks on the top ports of the USB device control block
`timescale 1ns/1ps
`default_nettype none
module usb_device_ctl_properties
  import usb_ctl_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [5:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        bus_reset_det,
  input wire logic        bus_suspend_det,
  input wire logic        bus_resume_det,
  input wire logic        sof_det,
  input wire logic        transfer_end,
  input wire logic        ep0_event,
  input wire logic        in1_event,
  input wire logic        out1_event,
  input wire logic        ep0_empty,
  input wire logic [6:0]  match_addr,
  input wire logic        core_inhibit,
  input wire logic        suspend_state_flag,
  input wire logic        usb_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Helpers
  // Core reset lands a cycle after the write, so checks look back two cycles
  logic pwr_rst_wr;
  assign pwr_rst_wr = reg_wr && (reg_addr == ADDR_POWER) && reg_wdata[P_CORE_RST];
  // Flag read with nothing arriving that could set a flag again
  sequence in_rd_quiet;
    reg_rd && (reg_addr == ADDR_IN_FLAGS) && !ep0_event && !in1_event;
  endsequence
  sequence in_rd;
    reg_rd && (reg_addr == ADDR_IN_FLAGS);
  endsequence
  // ==========================================================================
  // Assertions
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  flag_clear_a: assert property (in_rd_quiet ##1 in_rd |=> reg_rdata == 8'h00)
    else $error("flag read did not clear flags");
  addr_hold_a: assert property ((!transfer_end && !bus_reset_det && !pwr_rst_wr
    && !$past(pwr_rst_wr)) |=> $stable(match_addr))
    else $error("match address moved without transfer end");
  irq_cause_a: assert property ($rose(usb_irq) |-> $past(ep0_event || in1_event
    || out1_event || bus_reset_det || bus_resume_det || bus_suspend_det || sof_det))
    else $error("interrupt raised without an event");
  suspend_enter_a: assert property ($rose(suspend_state_flag) |-> $past(bus_suspend_det))
    else $error("suspend entered without suspend signaling");
  suspend_exit_a: assert property ((bus_resume_det || bus_reset_det)
    && !bus_suspend_det |=> !suspend_state_flag)
    else $error("suspend not left on resume or reset");
  inhibit_set_a: assert property ($rose(core_inhibit) |-> $past(pwr_rst_wr)
    || $past(pwr_rst_wr, 2))
    else $error("inhibit set without core reset");
  bus_flush_a: assert property (bus_reset_det |-> ##[1:2] (ep0_empty && match_addr == 7'h00))
    else $error("bus reset did not flush and clear address");
  fifo_load_a: assert property (reg_wr && (reg_addr == ADDR_FIFO_EP0) && !core_inhibit
    && !bus_reset_det && !$past(pwr_rst_wr) |=> !ep0_empty)
    else $error("port write did not load the FIFO");
endmodule
bind usb_device_ctl usb_device_ctl_properties u_props (.clk_sys, .rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .bus_reset_det, .bus_suspend_det,
  .bus_resume_det, .sof_det, .transfer_end, .ep0_event, .in1_event, .out1_event, .ep0_empty,
  .match_addr, .core_inhibit, .suspend_state_flag, .usb_irq);
`default_nettype wire

// ===== usb_host_model.sv
// Far-side model: serial engine event pulses and endpoint FIFO traffic
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic        clk_sys,
  output logic [12:0]      ev,
  output logic [10:0]      sof_frame,
  output logic [7:0]       sie_wdata
);
  // ==========================================================================
  // Idle levels
  initial
  begin
    ev        = '0;
    sof_frame = '0;
    sie_wdata = '0;
  end
  // One pulse a call; released data shows the inverse so stale data never looks valid
  task automatic send(input int idx, input logic [10:0] val);
    @(negedge clk_sys);
    ev        = 13'h0001 << idx;
    sof_frame = val;
    sie_wdata = val[7:0];
    @(negedge clk_sys);
    ev        = '0;
    sof_frame = ~val;
    sie_wdata = ~val[7:0];
  endtask
endmodule
`default_nettype wire

// ===== usb_device_ctl_tb.sv
// Self-checking bench for the USB device control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module usb_device_ctl_tb;
  import usb_ctl_pkg::*;
  typedef struct packed { logic [5:0] a; logic [7:0] e; } row_t;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  reg_addr = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = '0;
  logic        ep1_split = 1'b0;
  logic        ep1_iso = 1'b0;
  logic [12:0] ev;
  logic [10:0] sof_frame;
  logic [7:0]  sie_wdata, reg_rdata, ep0_rd, in1_rd;
  logic [6:0]  match_addr;
  logic        reg_rvalid, ep0_empty, iso_send_zlp, core_inhibit, suspend_state_flag;
  logic        resume_drive, usb_irq, in1_empty, out1_full;
  int          fail_count = 0;
  int          checks = 0;
  // Reset values of every readable register except index, plus an unmapped address
  row_t rows [8] = '{'{ADDR_FUNC_ADDR, 8'h00}, '{ADDR_POWER, 8'h10}, '{ADDR_IN_FLAGS, 8'h00},
    '{ADDR_OUT_FLAGS, 8'h00}, '{ADDR_FRAME_LO, 8'h00}, '{ADDR_FRAME_HI, 8'h00},
    '{ADDR_COMMON, 8'h00}, '{6'h3F, 8'h00}};
  // ==========================================================================
  // Design and far side
  usb_device_ctl u_usb_device_ctl (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .bus_reset_det(ev[0]), .bus_suspend_det(ev[1]),
    .bus_resume_det(ev[2]), .sof_det(ev[3]), .sof_frame, .transfer_end(ev[4]),
    .ep0_event(ev[5]), .in1_event(ev[6]), .out1_event(ev[7]), .ep1_split, .ep1_iso,
    .sie_ep0_push(ev[9]), .sie_ep0_pop(ev[10]), .sie_out1_push(ev[11]), .sie_in1_pop(ev[12]),
    .sie_wdata, .sie_ep0_rdata(ep0_rd), .sie_in1_rdata(in1_rd), .ep0_empty, .in1_empty,
    .out1_full, .iso_in_loaded(ev[8]), .iso_send_zlp, .match_addr, .core_inhibit,
    .suspend_state_flag, .resume_drive, .usb_irq);
  usb_host_model u_usb_host_model (.clk_sys, .ev, .sof_frame, .sie_wdata);
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Register port tasks; strobes stay up until the next call or idle
  task automatic idle(input int n = 1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_rd    = 1'b0;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    reg_wr   = 1'b0;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    `CHK({reg_rvalid, reg_rdata & m}, {1'b1, e})
  endtask
  task automatic pulse(input int idx, input logic [10:0] v = '0);
    idle();
    u_usb_host_model.send(idx, v);
  endtask
  task automatic finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    idle();
    for (int i = 0; i < 8; i++)
    begin
      rd(rows[i].a, rows[i].e);
    end
    // Writes other than power are dropped while inhibited
    wr(ADDR_FUNC_ADDR, 8'h25);
    rd(ADDR_FUNC_ADDR, 8'h00);
    // core reset first, inhibit cleared last
    wr(ADDR_POWER, 8'h18);
    idle(3);
    wr(ADDR_POWER, 8'h11);
    wr(ADDR_POWER, 8'h01);
    idle();
    `CHK(core_inhibit, 1'b0)
    rd(ADDR_POWER, 8'h01);
    // Deferred address with pending flag
    wr(ADDR_FUNC_ADDR, 8'h25);
    rd(ADDR_FUNC_ADDR, 8'hA5);
    `CHK(match_addr, 7'h00)
    pulse(4);
    `CHK(match_addr, 7'h25)
    rd(ADDR_FUNC_ADDR, 8'h25);
    // Endpoint 0 FIFO both ways
    pulse(9, 11'h05A);
    pulse(9, 11'h0A5);
    rd(ADDR_FIFO_EP0, 8'h5A);
    rd(ADDR_FIFO_EP0, 8'hA5);
    idle();
    `CHK(ep0_empty, 1'b1)
    wr(ADDR_FIFO_EP0, 8'h33);
    pulse(10);
    `CHK(ep0_rd, 8'h33)
    // Split endpoint 1: reads from OUT, writes to IN
    ep1_split = 1'b1;
    pulse(11, 11'h03C);
    wr(ADDR_FIFO_EP1, 8'h77);
    rd(ADDR_FIFO_EP1, 8'h3C);
    pulse(12);
    `CHK(in1_rd, 8'h77)
    `CHK(in1_empty, 1'b1)
    repeat (128) pulse(11);
    `CHK(out1_full, 1'b1)
    // Flag registers, back-to-back reads clear them
    pulse(5);
    `CHK(usb_irq, 1'b1)
    pulse(6);
    rd(ADDR_IN_FLAGS, 8'h03);
    rd(ADDR_IN_FLAGS, 8'h00);
    pulse(7);
    rd(ADDR_OUT_FLAGS, 8'h02);
    rd(ADDR_OUT_FLAGS, 8'h00);
    idle();
    `CHK(usb_irq, 1'b0)
    // Suspend then resume from the bus
    pulse(1);
    `CHK(suspend_state_flag, 1'b1)
    rd(ADDR_POWER, 8'h03);
    pulse(2);
    `CHK(suspend_state_flag, 1'b0)
    rd(ADDR_COMMON, 8'h02);
    // Remote wakeup; resume held short of real time to keep the run brief
    pulse(1);
    wr(ADDR_POWER, 8'h05);
    idle();
    `CHK(resume_drive, 1'b1)
    idle(20);
    `CHK(suspend_state_flag, 1'b1)
    wr(ADDR_POWER, 8'h01);
    idle();
    `CHK(suspend_state_flag, 1'b0)
    // Frame number split over two registers
    pulse(3, 11'h5A3);
    rd(ADDR_FRAME_LO, 8'hA3);
    rd(ADDR_FRAME_HI, 8'h05);
    // Iso packet held until the next frame start
    wr(ADDR_POWER, 8'h81);
    ep1_iso = 1'b1;
    pulse(8);
    `CHK(iso_send_zlp, 1'b1)
    pulse(3, 11'h001);
    `CHK(iso_send_zlp, 1'b0)
    // Bus reset with data queued and an address in use
    pulse(9, 11'h011);
    pulse(0);
    `CHK({match_addr, ep0_empty, usb_irq}, {7'h00, 2'b11})
    rd(ADDR_POWER, 8'h08, 8'h08);
    rd(ADDR_COMMON, 8'h04);
    pulse(3, 11'h002);
    `CHK(usb_irq, 1'b1)
    rd(ADDR_COMMON, 8'h08);
    // Core reset in mid-run returns everything to defaults
    wr(ADDR_FUNC_ADDR, 8'h11);
    pulse(4);
    wr(ADDR_POWER, 8'h08);
    idle(3);
    `CHK({core_inhibit, match_addr}, {1'b1, 7'h00})
    rd(ADDR_POWER, 8'h10);
    rd(ADDR_FRAME_LO, 8'h00);
    idle();
    finish_test();
  end
endmodule
`default_nettype wire
